/* rtl/dpslc_pkg.sv */
// constants shared by both ends of the potentiometer serial link
package dpslc_pkg;

  // word layout: address bits first, then code bits, both msb first
  localparam int CODE_W   = 8;
  localparam int ADDR_W   = 2;
  localparam int WORD_W   = ADDR_W + CODE_W;
  localparam int ADDR_LSB = CODE_W;
  localparam int MAX_CH   = 4;

  // latch value forced by the midscale reset
  localparam logic [CODE_W-1:0] MID_CODE  = 8'h80;
  // tap selected while powered down: wiper sits on the low terminal
  localparam logic [CODE_W-1:0] ZERO_CODE = 8'h00;

  // serial clock timing
  localparam int CLK_PERIOD_NS      = 25;
  localparam int SCLK_MIN_PERIOD_NS = 100;
  localparam int SCLK_PERIOD_CYC    = (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC      = (SCLK_PERIOD_CYC + 1) / 2;

  // host timer width
  localparam int TMR_W = 8;

endpackage

/* rtl/dpslc_link_if.sv */
// link wires between the serial master and the potentiometer device
`timescale 1ns/10ps
`default_nettype none

interface dpslc_link_if;
  logic sclk;
  logic cs_n;
  logic serial_in;
  logic midscale_reset_n;
  logic power_down_n;
  logic chain_serial_out;
  logic chain_serial_oe;
  logic chain_level;

  // open drain with pull-up: the wire is low only while the device pulls it
  assign chain_level = chain_serial_oe ? chain_serial_out : 1'b1;

  modport host (
    output sclk,
    output cs_n,
    output serial_in,
    output midscale_reset_n,
    output power_down_n,
    input  chain_level
  );

  modport device (
    input  sclk,
    input  cs_n,
    input  serial_in,
    input  midscale_reset_n,
    input  power_down_n,
    output chain_serial_out,
    output chain_serial_oe
  );
endinterface

`default_nettype wire

/* rtl/dpslc_sync.sv */
// two flip-flop level synchroniser, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none

module dpslc_sync
  import dpslc_pkg::*;
#(
  parameter int                 W        = 1,
  parameter logic [W-1:0]       RST_VAL  = '0
)(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // levels
  input  wire logic [W-1:0]     async_in,
  output logic      [W-1:0]     sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dpslc_sync_st_t;

  dpslc_sync_st_t st_ff;
  dpslc_sync_st_t nxt_st;

  if (W < 1)
  begin : g_chk
    $error("dpslc_sync: W must be at least 1");
  end

  always_comb
  begin
    nxt_st        = st_ff;
    nxt_st.meta   = async_in;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_ff <= {RST_VAL, RST_VAL};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.stable;

endmodule

`default_nettype wire

/* rtl/dpslc_device.sv */
// device end: serial shift register on the link clock, wiper latches on the system clock
`timescale 1ns/10ps
`default_nettype none

// How it works
// - one ten-bit serial word per wiper update
// - two address bits then eight code bits, msb first
// - channel number is two a_hi plus a_lo plus one
// - single channel part: master sends zero address
// - dual channel part: master sends zero upper address
// - words taken singly, channels in any order
// - serial clock up to 10 MHz
// - midscale reset forces every latch to 128
// - power down opens high terminal, wiper to low
// - power down keeps latches, restore on exit
// - serial input live in power down, chain off
// - codes written in power down apply afterwards
// - each latch holds eight bits, 256 positions
// - code zero at low end, one tap per step
// - shift on rising edge, chain out ten earlier
// - select rising loads addressed wiper latch
// - midscale reset holds latches, clears chain latch
// - last ten bits used; chain keeps select low
module dpslc_device
  import dpslc_pkg::*;
#(
  parameter int NCH = 4
)(
  // system clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   arst_n_in,
  // serial link, clocked by the master's serial clock
  dpslc_link_if.device                link,
  // latch contents
  output logic [NCH-1:0][CODE_W-1:0]  wiper_latch_out,
  // tap actually selected on each resistor, 0 = low terminal
  output logic [NCH-1:0][CODE_W-1:0]  wiper_tap_out,
  // analog switch controls
  output logic                        terminal_high_open_out,
  output logic                        wiper_to_low_out,
  // word events
  output logic                        load_pulse_out,
  output logic                        reject_pulse_out
);

  if (!(NCH == 1 || NCH == 2 || NCH == 4))
  begin : g_chk
    $error("dpslc_device: NCH must be 1, 2 or 4");
  end

  if (NCH > MAX_CH || MAX_CH > (1 << ADDR_W))
  begin : g_chk_addr
    $error("dpslc_device: address field cannot reach every channel");
  end

  // link clock domain
  typedef struct packed {
    logic [WORD_W-1:0] shift;
    logic              chain;
  } dpslc_lnk_st_t;

  dpslc_lnk_st_t lnk_ff;
  dpslc_lnk_st_t nxt_lnk;
  logic          rst_lnk_n;

  // the serial clock stops between frames, so the midscale pin clears
  // the chain latch asynchronously rather than waiting for an edge
  assign rst_lnk_n = arst_n_in & link.midscale_reset_n;

  always_comb
  begin
    nxt_lnk = lnk_ff;
    if (!link.cs_n)
    begin
      // the bit leaving the top is the one entered ten edges earlier
      nxt_lnk.chain = lnk_ff.shift[WORD_W-1];
      nxt_lnk.shift = {lnk_ff.shift[WORD_W-2:0], link.serial_in};
    end
  end

  always_ff @(posedge link.sclk or negedge rst_lnk_n)
  begin
    if (!rst_lnk_n)
    begin
      lnk_ff <= '0;
    end
    else
    begin
      lnk_ff <= nxt_lnk;
    end
  end

  // pin synchronisers into the system clock domain
  // select, power down and midscale come from another clock: two stages each
  logic cs_n_s;
  logic pd_n_s;
  logic mr_n_s;

  dpslc_sync #(
    .W       (3),
    .RST_VAL (3'h7)
  ) u_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .async_in  ({link.cs_n, link.power_down_n, link.midscale_reset_n}),
    .sync_out  ({cs_n_s, pd_n_s, mr_n_s})
  );

  // system clock domain: latches and switch controls
  typedef struct packed {
    logic [NCH-1:0][CODE_W-1:0] wiper;
    logic [NCH-1:0][CODE_W-1:0] tap;
    logic                       cs_prev;
    logic                       high_open;
    logic                       load;
    logic                       reject;
  } dpslc_dev_st_t;

  dpslc_dev_st_t dev_ff;
  dpslc_dev_st_t nxt_dev;
  logic [ADDR_W-1:0] word_addr;
  logic [CODE_W-1:0] word_code;
  logic              select_rise;

  // the shift register is only read after select has risen, while the
  // serial clock is parked, so the word is static when it is sampled;
  // the master must leave a gap before the next frame for this reason
  assign word_addr   = lnk_ff.shift[WORD_W-1:ADDR_LSB];
  assign word_code   = lnk_ff.shift[CODE_W-1:0];
  assign select_rise = cs_n_s & !dev_ff.cs_prev;

  // one address comparator per channel; channel g+1 answers address g
  logic [NCH-1:0] ch_hit;

  for (genvar g = 0; g < NCH; g++)
  begin : g_hit
    assign ch_hit[g] = (word_addr == ADDR_W'(g));
  end

  always_comb
  begin
    nxt_dev         = dev_ff;
    nxt_dev.load    = 1'b0;
    nxt_dev.reject  = 1'b0;
    nxt_dev.cs_prev = cs_n_s;
    if (!mr_n_s)
    begin
      // held at midscale for as long as the pin is low
      for (int i = 0; i < NCH; i++)
      begin
        nxt_dev.wiper[i] = MID_CODE;
      end
    end
    else if (select_rise)
    begin
      // any channel, any order, one word per select pulse
      nxt_dev.reject = 1'b1;
      for (int i = 0; i < NCH; i++)
      begin
        if (ch_hit[i])
        begin
          nxt_dev.wiper[i] = word_code;
          nxt_dev.load     = 1'b1;
          nxt_dev.reject   = 1'b0;
        end
      end
    end
    // power down only redirects the tap; the latch itself is untouched
    nxt_dev.high_open = !pd_n_s;
    for (int i = 0; i < NCH; i++)
    begin
      nxt_dev.tap[i] = pd_n_s ? nxt_dev.wiper[i] : ZERO_CODE;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      dev_ff.wiper     <= {NCH{MID_CODE}};
      dev_ff.tap       <= {NCH{MID_CODE}};
      dev_ff.cs_prev   <= 1'b1;
      dev_ff.high_open <= 1'b0;
      dev_ff.load      <= 1'b0;
      dev_ff.reject    <= 1'b0;
    end
    else
    begin
      dev_ff <= nxt_dev;
    end
  end

  // outputs
  assign wiper_latch_out        = dev_ff.wiper;
  assign wiper_tap_out          = dev_ff.tap;
  assign terminal_high_open_out = dev_ff.high_open;
  assign wiper_to_low_out       = dev_ff.high_open;
  assign load_pulse_out         = dev_ff.load;
  assign reject_pulse_out       = dev_ff.reject;

  // open drain: pull low only for a zero, only while selected and awake;
  // released in power down so no current flows in the pull-up
  logic chain_drive;
  assign chain_drive           = !lnk_ff.chain & !link.cs_n & pd_n_s;
  assign link.chain_serial_out = 1'b0;
  assign link.chain_serial_oe  = chain_drive;

endmodule

`default_nettype wire

/* rtl/dpslc_host.sv */
// host end: serial master that sends one ten-bit word per request
`timescale 1ns/10ps
`default_nettype none

module dpslc_host
  import dpslc_pkg::*;
#(
  parameter int NCH     = 4,
  parameter int GAP_CYC = 8
)(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // serial link, serial clock made here by division
  dpslc_link_if.host             link,
  // user request
  input  wire logic              req_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [CODE_W-1:0] code_in,
  input  wire logic              midscale_reset_n_in,
  input  wire logic              power_down_n_in,
  // user status
  output logic                   ready_out,
  output logic                   done_out
);

  if (!(NCH == 1 || NCH == 2 || NCH == 4) || GAP_CYC < 1 || GAP_CYC >= (1 << TMR_W))
  begin : g_chk
    $error("dpslc_host: NCH must be 1, 2 or 4 and GAP_CYC 1..255");
  end

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_LOW,
    HS_HIGH,
    HS_TAIL,
    HS_GAP
  } dpslc_hstate_t;

  typedef struct packed {
    dpslc_hstate_t     state;
    logic [WORD_W-1:0] word;
    logic [3:0]        bits;
    logic [TMR_W-1:0]  tmr;
    logic              sclk;
    logic              cs_n;
    logic              mr_n;
    logic              pd_n;
    logic              done;
  } dpslc_host_st_t;

  localparam logic [TMR_W-1:0] HALF_LAST = TMR_W'(SCLK_HALF_CYC - 1);
  localparam logic [TMR_W-1:0] GAP_LAST  = TMR_W'(GAP_CYC - 1);
  localparam logic [3:0]       BIT_LAST  = 4'(WORD_W - 1);

  dpslc_host_st_t st_ff;
  dpslc_host_st_t nxt_st;
  logic [ADDR_W-1:0] addr_ok;

  always_comb
  begin
    addr_ok = addr_in;
    if (NCH < 4)
    begin
      addr_ok[1] = 1'b0;
    end
    if (NCH < 2)
    begin
      addr_ok[0] = 1'b0;
    end
  end

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.mr_n = midscale_reset_n_in;
    nxt_st.pd_n = power_down_n_in;
    nxt_st.tmr  = st_ff.tmr + TMR_W'(1);
    case (st_ff.state)
      HS_IDLE:
      begin
        nxt_st.tmr = '0;
        if (req_in)
        begin
          nxt_st.word  = {addr_ok, code_in};
          nxt_st.bits  = '0;
          nxt_st.cs_n  = 1'b0;
          nxt_st.state = HS_LOW;
        end
      end
      HS_LOW:
      begin
        // half periods of at least 50 ns keep the serial clock at 10 MHz or less
        if (st_ff.tmr == HALF_LAST)
        begin
          nxt_st.tmr   = '0;
          nxt_st.sclk  = 1'b1;
          nxt_st.state = HS_HIGH;
        end
      end
      HS_HIGH:
      begin
        if (st_ff.tmr == HALF_LAST)
        begin
          nxt_st.tmr  = '0;
          nxt_st.sclk = 1'b0;
          nxt_st.bits = st_ff.bits + 4'h1;
          if (st_ff.bits == BIT_LAST)
          begin
            nxt_st.state = HS_TAIL;
          end
          else
          begin
            // data changes on the falling edge, half a period before sampling
            nxt_st.word  = {st_ff.word[WORD_W-2:0], 1'b0};
            nxt_st.state = HS_LOW;
          end
        end
      end
      HS_TAIL:
      begin
        if (st_ff.tmr == HALF_LAST)
        begin
          nxt_st.tmr   = '0;
          nxt_st.cs_n  = 1'b1;
          nxt_st.state = HS_GAP;
        end
      end
      HS_GAP:
      begin
        // lets the device latch the word before the next frame shifts
        if (st_ff.tmr == GAP_LAST)
        begin
          nxt_st.done  = 1'b1;
          nxt_st.state = HS_IDLE;
        end
      end
      default:
      begin
        nxt_st.state = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_ff       <= '0;
      st_ff.state <= HS_IDLE;
      st_ff.cs_n  <= 1'b1;
      st_ff.mr_n  <= 1'b0;
      st_ff.pd_n  <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign link.sclk             = st_ff.sclk;
  assign link.cs_n             = st_ff.cs_n;
  assign link.serial_in        = st_ff.word[WORD_W-1];
  assign link.midscale_reset_n = st_ff.mr_n;
  assign link.power_down_n     = st_ff.pd_n;
  assign ready_out             = (st_ff.state == HS_IDLE);
  assign done_out              = st_ff.done;

endmodule

`default_nettype wire

/* verif/dpslc_assertions.sv */
// concurrent checks on the wires between serial master and potentiometer device
`timescale 1ns/10ps
`default_nettype none

module dpslc_assertions (
  // system clock and reset
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // link wires
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic serial_in,
  input  wire logic midscale_reset_n,
  input  wire logic power_down_n,
  input  wire logic chain_serial_out,
  input  wire logic chain_serial_oe,
  input  wire logic chain_level
);
  logic [3:0] nbit_ff;
  logic [9:0] hist_ff;
  logic       chain_exp_ff;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // shadow of the device shift register, so the chain bit is known ten shifts on
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      nbit_ff      <= 4'h0;
      hist_ff      <= 10'h000;
      chain_exp_ff <= 1'b0;
    end
    else
    begin
      if (cs_n)
        nbit_ff <= 4'h0;
      else if ($rose(sclk))
        nbit_ff <= nbit_ff + 4'h1;
      if (!midscale_reset_n)
      begin
        hist_ff      <= 10'h000;
        chain_exp_ff <= 1'b0;
      end
      else if ($rose(sclk) && !cs_n)
        {chain_exp_ff, hist_ff} <= {hist_ff, serial_in};
    end
  end

  frame_ten_bits_a: assert property ($rose(cs_n) |-> nbit_ff == 4'ha)
    else $error("frame did not carry ten clock rises");
  idle_clock_low_a: assert property (cs_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  clock_high_time_a: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("serial clock high phase not two cycles");
  clock_low_time_a: assert property ($fell(sclk) |=> !sclk)
    else $error("serial clock low phase too short");
  data_stable_a: assert property (sclk |-> $stable(serial_in))
    else $error("serial data moved while clock high");
  select_after_clock_a: assert property ($rose(cs_n) |-> !sclk && !$past(sclk))
    else $error("select rose too close to a clock edge");
  chain_off_pd_a: assert property ((!power_down_n)[*4] |-> !chain_serial_oe)
    else $error("chain output driven in power down");
  chain_off_idle_a: assert property (cs_n[*4] |-> !chain_serial_oe)
    else $error("chain output driven while deselected");
  chain_delay_a: assert property ((!cs_n && power_down_n)[*4] ##0 (sclk && $past(sclk))
    |-> chain_level == chain_exp_ff)
    else $error("chain output not the bit from ten shifts back");
  chain_open_drain_a: assert property (!chain_serial_out)
    else $error("chain output driven high");

  cover property ($rose(cs_n));
  cover property ($fell(power_down_n));
  cover property (!cs_n && !chain_level && !midscale_reset_n);
endmodule

`default_nettype wire

/* verif/tb.sv */
// testbench: host and device joined, plus a bench-driven two-channel device
`timescale 1ns/10ps
`default_nettype none

module tb;
  import dpslc_pkg::*;
  logic                   clk_in    = 1'b0;
  logic                   arst_n_in = 1'b0;
  logic                   lclk      = 1'b0;
  logic                   sen, req, mid_n, pd_n, rdy, done, ld, rj, ld2, rj2, hi_open, w_low;
  logic [ADDR_W-1:0]      addr;
  logic [CODE_W-1:0]      code;
  logic [3:0][CODE_W-1:0] lat, tap;
  logic [1:0][CODE_W-1:0] lat2;
  logic [CODE_W-1:0]      exp_c [4];
  int                     n_mismatch = 0;
  int                     n_checks   = 0;
  int                     n_load     = 0;
  int                     n_load2    = 0;
  int                     n_rej      = 0;
  int                     n_rej2     = 0;
  int                     n_sent     = 0;
  int                     seed       = 38617;

  dpslc_link_if lnk ();
  dpslc_link_if lnk2 ();

  always #12.5 clk_in = ~clk_in;
  // bench-made link clock, gated so it stands still between frames
  always #7.5 lclk = ~lclk;
  assign lnk2.sclk = lclk & sen;

  dpslc_host u_dpslc_host (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(lnk.host), .req_in(req),
    .addr_in(addr), .code_in(code), .midscale_reset_n_in(mid_n), .power_down_n_in(pd_n),
    .ready_out(rdy), .done_out(done));
  dpslc_device u_dpslc_device (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(lnk.device),
    .wiper_latch_out(lat), .wiper_tap_out(tap), .terminal_high_open_out(hi_open),
    .wiper_to_low_out(w_low), .load_pulse_out(ld), .reject_pulse_out(rj));
  dpslc_device #(.NCH(2)) u_dpslc_device2 (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(lnk2.device),
    .wiper_latch_out(lat2), .wiper_tap_out(), .terminal_high_open_out(), .wiper_to_low_out(),
    .load_pulse_out(ld2), .reject_pulse_out(rj2));
  dpslc_assertions u_dpslc_assertions (.clk_in(clk_in), .arst_n_in(arst_n_in), .sclk(lnk.sclk),
    .cs_n(lnk.cs_n), .serial_in(lnk.serial_in), .midscale_reset_n(lnk.midscale_reset_n),
    .power_down_n(lnk.power_down_n), .chain_serial_out(lnk.chain_serial_out),
    .chain_serial_oe(lnk.chain_serial_oe), .chain_level(lnk.chain_level));

  always @(negedge clk_in)
  begin
    n_load += int'(ld === 1'b1);
    n_load2 += int'(ld2 === 1'b1);
    n_rej += int'(rj === 1'b1);
    n_rej2 += int'(rj2 === 1'b1);
  end

  function automatic logic [CODE_W-1:0] exp_tap(input int i);
    return pd_n ? exp_c[i] : ZERO_CODE;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_all();
    for (int i = 0; i < 4; i++)
    begin
      chk(16'(lat[i]), 16'(exp_c[i]));
      chk(16'(tap[i]), 16'(exp_tap(i)));
    end
  endtask

  task automatic send(input logic [1:0] a, input logic [7:0] c);
    int k;
    k = 0;
    @(posedge clk_in);
    req <= 1'b1;
    addr <= a;
    code <= c;
    @(posedge clk_in);
    req <= 1'b0;
    @(negedge clk_in);
    chk(16'(rdy), 16'h0);
    do
    begin
      @(negedge clk_in);
      k++;
    end
    while (done !== 1'b1 && k < 100);
    chk(16'(done), 16'h1);
    chk(16'(rdy), 16'h1);
    if (mid_n)
    begin
      exp_c[a] = c;
      n_sent++;
    end
    chk_all();
  endtask

  // sends the low n bits of w, msb first, on the second link
  task automatic frame2(input logic [11:0] w, input int n);
    @(negedge lclk);
    lnk2.cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(negedge lclk);
      lnk2.serial_in <= w[i];
      sen <= 1'b1;
    end
    @(negedge lclk);
    sen <= 1'b0;
    lnk2.serial_in <= ~w[0];
    @(negedge lclk);
    lnk2.cs_n <= 1'b1;
    repeat (8) @(negedge clk_in);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #(25 * 20000);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    {sen, req, addr, code, mid_n, pd_n} = {1'b0, 1'b0, 2'h0, 8'h00, 1'b1, 1'b1};
    {lnk2.cs_n, lnk2.serial_in, lnk2.midscale_reset_n, lnk2.power_down_n} = 4'b1001;
    for (int i = 0; i < 4; i++)
      exp_c[i] = MID_CODE;
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    lnk2.midscale_reset_n <= 1'b1;
    repeat (4) @(negedge clk_in);
    chk_all();
    chk(16'(lat2), {MID_CODE, MID_CODE});
    $display("reset test done");
    send(2'h0, 8'h00);
    send(2'h3, 8'hff);
    send(2'h3, 8'h01);
    for (int i = 0; i < 16; i++)
      send(2'($random(seed)), 8'($random(seed)));
    $display("random word test done");
    @(posedge clk_in);
    pd_n <= 1'b0;
    repeat (6) @(negedge clk_in);
    chk(16'({hi_open, w_low}), 16'h3);
    chk_all();
    send(2'h2, 8'h3c);
    @(posedge clk_in);
    pd_n <= 1'b1;
    repeat (6) @(negedge clk_in);
    chk(16'({hi_open, w_low}), 16'h0);
    chk_all();
    $display("power down test done");
    @(posedge clk_in);
    mid_n <= 1'b0;
    for (int i = 0; i < 4; i++)
      exp_c[i] = MID_CODE;
    repeat (6) @(negedge clk_in);
    chk_all();
    send(2'h1, 8'h11);
    @(posedge clk_in);
    mid_n <= 1'b1;
    repeat (6) @(negedge clk_in);
    chk_all();
    $display("midscale test done");
    frame2({2'h0, 2'h1, 8'h5a}, 12);
    chk(16'(lat2), {8'h5a, MID_CODE});
    frame2({2'h0, 2'h2, 8'hc3}, 10);
    chk(16'(lat2), {8'h5a, MID_CODE});
    chk(16'(n_rej2), 16'h1);
    chk(16'(n_load2), 16'h1);
    $display("short device test done");
    chk(16'(n_load), 16'(n_sent));
    chk(16'(n_rej), 16'h0);
    stop_test();
  end
endmodule

`default_nettype wire
